// ### core/pwc_params.svh
// Purpose: constants for the phase change memory command host
// Assumes: 25 MHz clock, 16-bit asynchronous memory bus
// Notes:   command codes and bus timing counts
`ifndef PWC_PARAMS_SVH
`define PWC_PARAMS_SVH

// ---------------------------------------------------------------
// command codes
// ---------------------------------------------------------------
`define PWC_CMD_READ_ARRAY   8'hff
`define PWC_CMD_BUF_PROG     8'he8
`define PWC_CMD_BUF_BITALT   8'hea
`define PWC_CMD_CONFIRM      8'hd0
`define PWC_CMD_SUSPEND      8'hb0
`define PWC_CMD_LOCK_SETUP   8'h60
`define PWC_CMD_CLEAR_STATUS 8'h50
`define PWC_CMD_READ_STATUS  8'h70
`define PWC_CMD_LOCK         8'h01
`define PWC_CMD_LOCK_DOWN    8'h2f
`define PWC_CMD_CFG_RCR      8'h03
`define PWC_CMD_CFG_ECR      8'h04

// ---------------------------------------------------------------
// bus timing
// ---------------------------------------------------------------
`define PWC_CLK_PERIOD_NS    40
`define PWC_WE_LOW_NS        70
`define PWC_WE_HIGH_NS       40
`define PWC_RD_ACCESS_NS     135
`define PWC_WE_LOW_CYC  ((`PWC_WE_LOW_NS + `PWC_CLK_PERIOD_NS - 1) / `PWC_CLK_PERIOD_NS)
`define PWC_WE_HIGH_CYC ((`PWC_WE_HIGH_NS + `PWC_CLK_PERIOD_NS - 1) / `PWC_CLK_PERIOD_NS)
`define PWC_RD_CYC      ((`PWC_RD_ACCESS_NS + `PWC_CLK_PERIOD_NS - 1) / `PWC_CLK_PERIOD_NS)

// ---------------------------------------------------------------
// widths and status bits
// ---------------------------------------------------------------
`define PWC_AW               23
`define PWC_DW               16
`define PWC_BLK_LSB          16
`define PWC_CNT_W            5
`define PWC_SR_READY_BIT     7

`endif

// ### core/pwc_pkg.sv
// Purpose: types for the phase change memory command host
// Assumes: constants come from pwc_params.svh
// Notes:   no timescale, package only
`include "pwc_params.svh"

package pwc_pkg;
  // -------------------------------------------------------------
  // user request kinds
  // -------------------------------------------------------------
  typedef enum logic [2:0] {
    PWC_OP_BUF_PROG,
    PWC_OP_LOCK_CFG,
    PWC_OP_SUSPEND,
    PWC_OP_RESUME,
    PWC_OP_CLEAR,
    PWC_OP_READ_STATUS,
    PWC_OP_RAW
  } pwc_op_t;

  typedef struct packed {
    pwc_op_t                 op;
    logic                    bit_alt;
    logic [7:0]              code;
    logic [`PWC_AW-1:0]      addr;
    logic [`PWC_CNT_W-1:0]   count;
  } pwc_req_t;

  // one bus cycle handed to the pin driver
  typedef struct packed {
    logic                    rd;
    logic [`PWC_AW-1:0]      addr;
    logic [`PWC_DW-1:0]      data;
  } pwc_cyc_t;

  typedef struct packed {
    logic                    ce_n;
    logic                    we_n;
    logic                    oe_n;
    logic [`PWC_AW-1:0]      addr;
    logic [`PWC_DW-1:0]      dq_o;
    logic                    dq_oe;
  } pwc_pins_t;
endpackage : pwc_pkg

// ### core/pwc_bus_cycle.sv
// Purpose: drives one asynchronous write or read cycle on the pins
// Assumes: 25 MHz clock, pins registered
// Notes:   read data sampled through two flops
`timescale 1ns/100ps
`include "pwc_params.svh"

module pwc_bus_cycle (
  input  wire logic               i_clk,
  input  wire logic               i_arst_n,
  input  wire pwc_pkg::pwc_cyc_t  i_cyc,
  input  wire logic               i_start,
  input  wire logic [`PWC_DW-1:0] i_dq,
  output pwc_pkg::pwc_pins_t      o_pins,
  output logic                    o_done,
  output logic [`PWC_DW-1:0]      o_rdata
);
  typedef enum logic [1:0] {PWC_BC_IDLE, PWC_BC_ACT, PWC_BC_GAP} pwc_bc_t;

  pwc_bc_t            state_reg;
  logic [2:0]         cnt_reg;
  pwc_pkg::pwc_pins_t pins_reg;
  logic [`PWC_DW-1:0] dq_s1_reg;
  logic [`PWC_DW-1:0] dq_s2_reg;
  logic               done_reg;
  logic [`PWC_DW-1:0] rdata_reg;
  wire  [2:0]         act_len = i_cyc.rd ? 3'(`PWC_RD_CYC + 2) : 3'(`PWC_WE_LOW_CYC);

  // -------------------------------------------------------------
  // pin synchroniser, data lines cross from the device
  // -------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dq_s1_reg <= '0;
      dq_s2_reg <= '0;
    end else begin
      dq_s1_reg <= i_dq;
      dq_s2_reg <= dq_s1_reg;
    end
  end

  // -------------------------------------------------------------
  // cycle sequencer
  // -------------------------------------------------------------
  // read length adds two for the synchroniser delay
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= PWC_BC_IDLE;
      cnt_reg   <= '0;
      pins_reg  <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, default: '0};
      done_reg  <= 1'b0;
      rdata_reg <= '0;
    end else begin
      done_reg <= 1'b0;
      unique case (state_reg)
        PWC_BC_IDLE: if (i_start) begin
          pins_reg.ce_n  <= 1'b0;
          pins_reg.we_n  <= i_cyc.rd;
          pins_reg.oe_n  <= !i_cyc.rd;
          pins_reg.addr  <= i_cyc.addr;
          pins_reg.dq_o  <= i_cyc.data;
          pins_reg.dq_oe <= !i_cyc.rd;
          cnt_reg        <= act_len;
          state_reg      <= PWC_BC_ACT;
        end
        PWC_BC_ACT: if (cnt_reg > 3'd1) begin
          cnt_reg <= cnt_reg - 3'd1;
        end else begin
          // we rises first, data held one more cycle as hold time
          pins_reg.ce_n <= 1'b1;
          pins_reg.we_n <= 1'b1;
          pins_reg.oe_n <= 1'b1;
          rdata_reg     <= dq_s2_reg;
          cnt_reg       <= 3'(`PWC_WE_HIGH_CYC);
          state_reg     <= PWC_BC_GAP;
        end
        PWC_BC_GAP: if (cnt_reg > 3'd1) begin
          cnt_reg <= cnt_reg - 3'd1;
        end else begin
          pins_reg.dq_oe <= 1'b0;
          done_reg       <= 1'b1;
          state_reg      <= PWC_BC_IDLE;
        end
      endcase
    end
  end

  assign o_pins  = pins_reg;
  assign o_done  = done_reg;
  assign o_rdata = rdata_reg;

  a_we_pulse_len: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $fell(pins_reg.we_n) |-> !pins_reg.we_n [*2] ##1 pins_reg.we_n)
    else $error("write strobe width wrong");
endmodule : pwc_bus_cycle

// ### core/pwc_host.sv
// Purpose: host controller issuing command sequences to a phase change memory
// Assumes: device tracks its own write engine; host mirrors its mode
// Notes:   one request at a time, status polled after each sequence except a refused lock or configuration code
//
// Contract
// R1 - e8 or ea opens a buffered program
// R2 - load words until count reached, then confirm
// R3 - d0 confirm starts buffer programming
// R4 - bad confirm in suspend returns to suspend
// R5 - b0 suspends program nested in erase suspend
// R6 - d0 resumes suspended buffered program
// R7 - 60 opens lock or configuration setup
// R8 - second code picks lock, lock-down or config
// R9 - other second code gives lock error
// R10 - d0 in nested setup unlocks block
// R11 - 50 clears status error flags
// R12 - clear ignored while busy or suspended
// R13 - load outside latched block aborts sequence
// R14 - both cycles go to same address
// R15 - unlisted codes are illegal commands
`timescale 1ns/100ps
`include "pwc_params.svh"

module pwc_host (
  input  wire logic               i_clk,
  input  wire logic               i_arst_n,
  input  wire pwc_pkg::pwc_req_t  i_req,
  input  wire logic               i_req_valid,
  input  wire logic [`PWC_DW-1:0] i_wdata,
  input  wire logic [`PWC_DW-1:0] i_dq,
  output logic                    o_req_ready,
  output logic                    o_wdata_ready,
  output logic                    o_done,
  output logic [7:0]              o_status,
  output logic                    o_erase_susp,
  output logic                    o_ce_n,
  output logic                    o_we_n,
  output logic                    o_oe_n,
  output logic [`PWC_AW-1:0]      o_addr,
  output logic [`PWC_DW-1:0]      o_dq,
  output logic                    o_dq_oe
);
  typedef enum logic [2:0] {
    PWC_H_IDLE, PWC_H_CMD, PWC_H_COUNT, PWC_H_LOAD, PWC_H_SECOND, PWC_H_POLL, PWC_H_FIN
  } pwc_hst_t;

  pwc_hst_t              state_reg;
  pwc_pkg::pwc_req_t     req_reg;
  logic [`PWC_CNT_W-1:0] left_reg;
  logic                  busy_reg;
  logic                  esusp_reg;
  logic                  req_ready_reg;
  logic                  wready_reg;
  logic                  done_reg;
  logic [7:0]            status_reg;
  logic                  start_reg;
  pwc_pkg::pwc_cyc_t     cyc_reg;
  pwc_pkg::pwc_pins_t    pins;
  logic                  cyc_done;
  logic [`PWC_DW-1:0]    rdata;

  // -------------------------------------------------------------
  // decode
  // -------------------------------------------------------------
  function automatic logic blk_same(input logic [`PWC_AW-1:0] a, input logic [`PWC_AW-1:0] b);
    blk_same = a[`PWC_AW-1:`PWC_BLK_LSB] == b[`PWC_AW-1:`PWC_BLK_LSB];
  endfunction : blk_same

  wire       is_buf    = i_req.op == pwc_pkg::PWC_OP_BUF_PROG;
  wire [7:0] buf_code  = i_req.bit_alt ? `PWC_CMD_BUF_BITALT : `PWC_CMD_BUF_PROG; // see R1
  wire       lock_ok   = (req_reg.code == `PWC_CMD_LOCK) || (req_reg.code == `PWC_CMD_LOCK_DOWN)
                       || (req_reg.code == `PWC_CMD_CFG_RCR) || (req_reg.code == `PWC_CMD_CFG_ECR)
                       || (req_reg.code == `PWC_CMD_CONFIRM && esusp_reg); // see R8, R10
  // clearing status while busy has no effect, so the host holds it back
  wire       clr_block = (i_req.op == pwc_pkg::PWC_OP_CLEAR) && busy_reg; // see R12
  wire       load_bad  = !blk_same(i_req.addr, req_reg.addr); // see R13
  wire [7:0] first_code =
      is_buf                                    ? buf_code :
      (i_req.op == pwc_pkg::PWC_OP_LOCK_CFG)    ? `PWC_CMD_LOCK_SETUP :       // see R7
      (i_req.op == pwc_pkg::PWC_OP_SUSPEND)     ? `PWC_CMD_SUSPEND :          // see R5
      (i_req.op == pwc_pkg::PWC_OP_RESUME)      ? `PWC_CMD_CONFIRM :          // see R6
      (i_req.op == pwc_pkg::PWC_OP_CLEAR)       ? `PWC_CMD_CLEAR_STATUS :     // see R11
      (i_req.op == pwc_pkg::PWC_OP_READ_STATUS) ? `PWC_CMD_READ_STATUS : i_req.code;

  // -------------------------------------------------------------
  // sequence engine
  // -------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg     <= PWC_H_IDLE;
      req_reg       <= '0;
      left_reg      <= '0;
      busy_reg      <= 1'b0;
      esusp_reg     <= 1'b0;
      req_ready_reg <= 1'b1;
      wready_reg    <= 1'b0;
      done_reg      <= 1'b0;
      status_reg    <= '0;
      start_reg     <= 1'b0;
      cyc_reg       <= '0;
    end else begin
      done_reg  <= 1'b0;
      start_reg <= 1'b0;
      unique case (state_reg)
        PWC_H_IDLE: if (i_req_valid && !clr_block) begin
          req_reg       <= i_req;
          left_reg      <= i_req.count;
          req_ready_reg <= 1'b0;
          cyc_reg       <= '{rd: 1'b0, addr: i_req.addr, data: {8'h00, first_code}};
          start_reg     <= 1'b1;
          state_reg     <= PWC_H_CMD;
        end
        PWC_H_CMD: if (cyc_done) begin
          unique case (req_reg.op)
            pwc_pkg::PWC_OP_BUF_PROG: begin
              // count word is n-1, same block address
              cyc_reg   <= '{rd: 1'b0, addr: req_reg.addr, data: 16'(req_reg.count)};
              start_reg <= 1'b1;
              state_reg <= PWC_H_COUNT;
            end
            pwc_pkg::PWC_OP_LOCK_CFG: begin
              // second cycle to the very same address
              cyc_reg   <= '{rd: 1'b0, addr: req_reg.addr, data: {8'h00, req_reg.code}}; // see R14
              start_reg <= lock_ok;
              state_reg <= lock_ok ? PWC_H_SECOND : PWC_H_FIN; // see R9, R15
            end
            pwc_pkg::PWC_OP_SUSPEND: begin
              busy_reg <= 1'b1;
              state_reg <= PWC_H_POLL;
              cyc_reg   <= '{rd: 1'b1, addr: req_reg.addr, data: '0};
              start_reg <= 1'b1;
            end
            default: begin
              cyc_reg   <= '{rd: 1'b1, addr: req_reg.addr, data: '0};
              start_reg <= 1'b1;
              busy_reg  <= req_reg.op == pwc_pkg::PWC_OP_RESUME;
              state_reg <= PWC_H_POLL;
            end
          endcase
        end
        PWC_H_COUNT: if (cyc_done) begin
          wready_reg <= 1'b1;
          state_reg  <= PWC_H_LOAD;
        end
        PWC_H_LOAD: begin
          if (wready_reg && i_req_valid && is_buf) begin
            // a foreign word still goes out so the device leaves load; its error is polled
            wready_reg <= 1'b0;
            cyc_reg    <= '{rd: 1'b0, addr: i_req.addr, data: i_wdata};
            start_reg  <= 1'b1;
            if (load_bad) begin
              state_reg <= PWC_H_SECOND; // see R13
            end
          end else if (cyc_done) begin
            if (left_reg == '0) begin
              cyc_reg   <= '{rd: 1'b0, addr: req_reg.addr, data: {8'h00, `PWC_CMD_CONFIRM}}; // see R3
              start_reg <= 1'b1;
              busy_reg  <= 1'b1;
              state_reg <= PWC_H_SECOND; // see R2
            end else begin
              left_reg   <= left_reg - 1'b1;
              wready_reg <= 1'b1;
            end
          end
        end
        PWC_H_SECOND: if (cyc_done) begin
          cyc_reg   <= '{rd: 1'b1, addr: req_reg.addr, data: '0};
          start_reg <= 1'b1;
          state_reg <= PWC_H_POLL;
        end
        PWC_H_POLL: if (cyc_done) begin
          status_reg <= rdata[7:0];
          if (rdata[`PWC_SR_READY_BIT]) begin
            state_reg <= PWC_H_FIN;
          end else begin
            start_reg <= 1'b1;
          end
        end
        PWC_H_FIN: begin
          // suspend from ready state reported as erase suspended, mode mirror
          if (req_reg.op == pwc_pkg::PWC_OP_SUSPEND) begin
            esusp_reg <= !esusp_reg || busy_reg; // see R4
          end
          if (req_reg.op == pwc_pkg::PWC_OP_BUF_PROG || req_reg.op == pwc_pkg::PWC_OP_RESUME) begin
            busy_reg <= 1'b0;
          end
          if (req_reg.op == pwc_pkg::PWC_OP_SUSPEND) begin
            busy_reg <= 1'b1;
          end
          done_reg      <= 1'b1;
          req_ready_reg <= 1'b1;
          state_reg     <= PWC_H_IDLE;
        end
      endcase
    end
  end

  pwc_bus_cycle u_cycle (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_cyc    (cyc_reg),
    .i_start  (start_reg),
    .i_dq     (i_dq),
    .o_pins   (pins),
    .o_done   (cyc_done),
    .o_rdata  (rdata)
  );

  assign o_req_ready   = req_ready_reg;
  assign o_wdata_ready = wready_reg;
  assign o_done        = done_reg;
  assign o_status      = status_reg;
  assign o_erase_susp  = esusp_reg;
  assign o_ce_n        = pins.ce_n;
  assign o_we_n        = pins.we_n;
  assign o_oe_n        = pins.oe_n;
  assign o_addr        = pins.addr;
  assign o_dq          = pins.dq_o;
  assign o_dq_oe       = pins.dq_oe;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  sequence s_count_sent;
    state_reg == PWC_H_COUNT && cyc_done;
  endsequence

  a_buf_entry_code: assert property (@(posedge i_clk) disable iff (!i_arst_n) // see R1
    state_reg == PWC_H_CMD && req_reg.op == pwc_pkg::PWC_OP_BUF_PROG && $rose(start_reg) |->
    cyc_reg.data[7:0] == (req_reg.bit_alt ? `PWC_CMD_BUF_BITALT : `PWC_CMD_BUF_PROG))
    else $error("buffer entry code");
  a_load_opens: assert property (@(posedge i_clk) disable iff (!i_arst_n) // see R2
    s_count_sent |=> wready_reg && state_reg == PWC_H_LOAD) else $error("load not opened");
  a_confirm_code: assert property (@(posedge i_clk) disable iff (!i_arst_n) // see R3
    state_reg == PWC_H_LOAD && cyc_done && left_reg == '0 |=>
    cyc_reg.data[7:0] == `PWC_CMD_CONFIRM && start_reg) else $error("confirm missing");
  a_same_addr: assert property (@(posedge i_clk) disable iff (!i_arst_n) // see R14
    state_reg == PWC_H_SECOND && start_reg && !$past(wready_reg) |-> cyc_reg.addr == req_reg.addr)
    else $error("second cycle address differs");
  a_abort_polls: assert property (@(posedge i_clk) disable iff (!i_arst_n) // see R13
    state_reg == PWC_H_LOAD && wready_reg && i_req_valid && is_buf && load_bad
    |=> state_reg == PWC_H_SECOND && start_reg) else $error("foreign word not followed by poll");
  a_clear_held: assert property (@(posedge i_clk) disable iff (!i_arst_n) // see R12
    state_reg == PWC_H_IDLE && clr_block |=> state_reg == PWC_H_IDLE)
    else $error("clear issued while busy");
  a_block_kept: assert property (@(posedge i_clk) disable iff (!i_arst_n) // see R13
    state_reg == PWC_H_LOAD && start_reg |-> blk_same(cyc_reg.addr, req_reg.addr))
    else $error("load outside block");
  a_lock_second: assert property (@(posedge i_clk) disable iff (!i_arst_n) // see R9
    state_reg == PWC_H_CMD && cyc_done && req_reg.op == pwc_pkg::PWC_OP_LOCK_CFG && !lock_ok
    |=> !start_reg && state_reg == PWC_H_FIN) else $error("bad lock code sent");
  a_done_pulse: assert property (@(posedge i_clk) disable iff (!i_arst_n) // see R15
    state_reg == PWC_H_FIN |=> done_reg && req_ready_reg ##1 !done_reg)
    else $error("done not a single pulse");
endmodule : pwc_host

// ### verification/pwc_dev_model.sv
// Purpose: behavioural model of the memory command interface seen by the host
// Assumes: write ends when ce_n or we_n rises, sampled on the host clock
// Notes:   erase and streaming paths left out; error bit positions assumed
`timescale 1ns/100ps
`include "pwc_params.svh"

module pwc_dev_model (
  input  wire logic               i_clk,
  input  wire logic               i_ce_n,
  input  wire logic               i_we_n,
  input  wire logic               i_oe_n,
  input  wire logic [`PWC_AW-1:0] i_addr,
  input  wire logic [`PWC_DW-1:0] i_dq,
  input  wire logic [7:0]         i_busy_cyc,
  output logic [`PWC_DW-1:0]      o_dq,
  output logic [7:0]              o_act,
  output logic [5:0]              o_nwords,
  output logic [`PWC_DW-1:0]      o_sum
);
  localparam logic [7:0] SEQ_ERR = 8'h30;
  typedef enum logic [2:0] {S_READY, S_SETUP, S_LOAD, S_CONF, S_BUSY, S_SUSP, S_LOCK} pwc_dst_t;
  pwc_dst_t           st       = S_READY;
  logic [7:0]         err      = 8'h00;
  logic               arr_mode = 1'b0;
  logic               wr_prev  = 1'b1;
  logic [`PWC_DW-1:0] idle_r   = 16'h5a5a;
  logic [6:0]         blk;
  logic [4:0]         rem;
  logic [7:0]         bcnt;
  logic [7:0]         code_r;
  logic [`PWC_AW-1:0] a_l;
  logic [`PWC_DW-1:0] d_l;
  wire                wr_n = i_ce_n | i_we_n;
  wire  [7:0]         status = {st != S_BUSY, 7'h00} | err | ((st == S_SUSP) ? 8'h04 : 8'h00);

  initial begin
    o_act    = 8'h00;
    o_nwords = 6'h00;
    o_sum    = 16'h0000;
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // released bus toggles every cycle so a stale value never passes
  assign o_dq = (!i_ce_n && !i_oe_n) ? (arr_mode ? ~i_addr[15:0] : {8'h00, status}) : idle_r;

  // ---------------------------------------------------------------
  // command decoding
  // ---------------------------------------------------------------
  task automatic write_cmd(input logic [`PWC_AW-1:0] a, input logic [`PWC_DW-1:0] d);
    case (st)
      S_READY: begin
        arr_mode <= (d[7:0] == `PWC_CMD_READ_ARRAY);
        if (d[7:0] == `PWC_CMD_BUF_PROG || d[7:0] == `PWC_CMD_BUF_BITALT) begin
          st     <= S_SETUP;
          blk    <= a[22:16];
          code_r <= d[7:0];
        end else if (d[7:0] == `PWC_CMD_LOCK_SETUP) begin
          st <= S_LOCK;
        end else if (d[7:0] == `PWC_CMD_CLEAR_STATUS) begin
          err <= 8'h00;
        end // other codes ignored
      end
      S_SETUP: begin
        rem      <= d[4:0];
        o_nwords <= 6'h00;
        o_sum    <= 16'h0000;
        st       <= S_LOAD;
      end
      S_LOAD: begin
        if (a[22:16] != blk) begin
          err <= SEQ_ERR;
          st  <= S_READY;
        end else begin
          o_sum    <= o_sum ^ d;
          o_nwords <= o_nwords + 6'h01;
          rem      <= rem - 5'h01;
          st       <= (rem == 5'h00) ? S_CONF : S_LOAD;
        end
      end
      S_CONF: begin
        st <= (d[7:0] == `PWC_CMD_CONFIRM) ? S_BUSY : S_READY;
        if (d[7:0] == `PWC_CMD_CONFIRM) o_act <= code_r;
        else err <= SEQ_ERR;
        bcnt <= i_busy_cyc;
      end
      // clear is ignored while running or suspended
      S_BUSY: if (d[7:0] == `PWC_CMD_SUSPEND) st <= S_SUSP;
      S_SUSP: if (d[7:0] == `PWC_CMD_CONFIRM) st <= S_BUSY;
      default: begin
        st <= S_READY;
        if (d[7:0] inside {8'h01, 8'h2f, 8'h03, 8'h04}) o_act <= d[7:0];
        else err <= SEQ_ERR;
      end
    endcase
  endtask : write_cmd

  // write capture while strobes low, acted on at the rising strobe
  always @(posedge i_clk) begin
    wr_prev <= wr_n;
    idle_r  <= ~idle_r;
    if (!wr_n) begin
      a_l <= i_addr;
      d_l <= i_dq;
    end
    if (st == S_BUSY) begin
      if (bcnt == 8'h00) st <= S_READY;
      else bcnt <= bcnt - 8'h01;
    end
    if (wr_n && !wr_prev) write_cmd(a_l, d_l);
  end
endmodule : pwc_dev_model

// ### verification/pwc_host_tb_top.sv
// Purpose: self-checking bench for the command host against a device model
// Assumes: one request at a time, status polled before done except after a refused lock code
// Notes:   results queued by the driver, checked when done pulses
`timescale 1ns/100ps
`include "pwc_params.svh"

module pwc_host_tb_top;
  typedef struct packed {
    logic [7:0]  st;
    logic [7:0]  act;
    logic [5:0]  nw;
    logic [15:0] sum;
  } pwc_exp_t;

  logic               i_clk     = 1'b0;
  logic               i_arst_n  = 1'b0;
  pwc_pkg::pwc_req_t  req       = '0;
  logic               req_valid = 1'b0;
  logic [15:0]        wdata     = 16'h0000;
  logic [7:0]         m_busy    = 8'h00;
  logic               o_req_ready, o_wdata_ready, o_done, o_erase_susp;
  logic               o_ce_n, o_we_n, o_oe_n, o_dq_oe;
  logic [7:0]         o_status, m_act;
  logic [5:0]         m_nw;
  logic [`PWC_AW-1:0] o_addr;
  logic [15:0]        o_dq, m_dq, m_sum;
  wire  [15:0]        dq_bus = o_dq_oe ? o_dq : m_dq;
  pwc_exp_t           exq[$];
  pwc_exp_t           sh = '{st: 8'h80, act: 8'h00, nw: 6'h00, sum: 16'h0000};
  pwc_exp_t           got;
  int                 error_cnt   = 0;
  int                 comparisons = 0;
  logic [7:0]         lock_codes [4] = '{8'h01, 8'h2f, 8'h03, 8'h04};

  // ---------------------------------------------------------------
  // design, device model, clock
  // ---------------------------------------------------------------
  pwc_host i_dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_req(req), .i_req_valid(req_valid),
    .i_wdata(wdata), .i_dq(dq_bus), .o_req_ready(o_req_ready), .o_wdata_ready(o_wdata_ready),
    .o_done(o_done), .o_status(o_status), .o_erase_susp(o_erase_susp), .o_ce_n(o_ce_n),
    .o_we_n(o_we_n), .o_oe_n(o_oe_n), .o_addr(o_addr), .o_dq(o_dq), .o_dq_oe(o_dq_oe));
  pwc_dev_model i_dev (.i_clk(i_clk), .i_ce_n(o_ce_n), .i_we_n(o_we_n), .i_oe_n(o_oe_n),
    .i_addr(o_addr), .i_dq(dq_bus), .i_busy_cyc(m_busy), .o_dq(m_dq), .o_act(m_act),
    .o_nwords(m_nw), .o_sum(m_sum));

  initial begin
    forever #20 i_clk = ~i_clk;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic summarize;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  // bounded wait; a hang counts as a mismatch instead of stalling
  task automatic wait_for(input logic wd);
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while ((wd ? o_wdata_ready : o_req_ready) !== 1'b1 && n < 2000);
    if (n >= 2000) error_cnt++;
  endtask : wait_for

  // one request; bad >= 0 puts that buffer word outside the block
  task automatic run_op(input pwc_pkg::pwc_op_t op, input logic [7:0] code, input int nw,
                        input int bad);
    logic [15:0] d;
    logic [6:0]  b;
    int          n;
    b = 7'($urandom);
    @(posedge i_clk);
    m_busy    <= 8'($urandom % 64);
    req       <= '{op: op, bit_alt: (code == 8'hea), code: code, addr: {b, 16'h0000},
                   count: 5'(nw - 1)};
    req_valid <= 1'b1;
    wait_for(1'b0);
    if (op == pwc_pkg::PWC_OP_BUF_PROG) begin
      sh.nw  = 6'h00;
      sh.sum = 16'h0000;
    end
    for (int i = 0; i < nw; i++) begin
      d = 16'($urandom);
      req.addr <= {(i == bad) ? b + 7'h01 : b, 16'($urandom)};
      wdata    <= d;
      wait_for(1'b1);
      if (i == bad) break;
      sh.nw  = sh.nw + 6'h01;
      sh.sum = sh.sum ^ d;
    end
    req_valid <= 1'b0;
    if (op == pwc_pkg::PWC_OP_BUF_PROG) begin
      sh.st = (bad < 0) ? 8'h80 : 8'hb0;
      if (bad < 0) sh.act = code;
    end else if (op == pwc_pkg::PWC_OP_LOCK_CFG && (code inside {8'h01, 8'h2f, 8'h03, 8'h04})) begin
      sh.st  = 8'h80;
      sh.act = code;
    end else if (op == pwc_pkg::PWC_OP_CLEAR) begin
      sh.st = 8'h80;
    end
    exq.push_back(sh);
    n = 0;
    while (exq.size() != 0 && n < 4000) begin
      @(posedge i_clk);
      n++;
    end
    if (n >= 4000) error_cnt++;
  endtask : run_op

  // ---------------------------------------------------------------
  // result monitor
  // ---------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_arst_n && o_done === 1'b1) begin
      if (exq.size() == 0) begin
        error_cnt++;
        $display("[ERR] done expected 0 seen 1");
      end else begin
        got = exq.pop_front();
        check("status", {8'h00, got.st}, {8'h00, o_status});
        check("action", {8'h00, got.act}, {8'h00, m_act});
        check("words", {10'h000, got.nw}, {10'h000, m_nw});
        check("checksum", got.sum, m_sum);
      end
    end
  end

  // ---------------------------------------------------------------
  // stimulus
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(75));
    repeat (11) @(posedge i_clk);
    check("idle pins", 16'h001e, {11'h000, o_ce_n, o_we_n, o_oe_n, o_req_ready, o_dq_oe});
    @(posedge i_clk);
    i_arst_n <= 1'b1;
    run_op(pwc_pkg::PWC_OP_BUF_PROG, 8'he8, 1, -1);
    run_op(pwc_pkg::PWC_OP_BUF_PROG, 8'hea, 32, -1);
    run_op(pwc_pkg::PWC_OP_BUF_PROG, 8'he8, 1 + $urandom % 32, -1);
    foreach (lock_codes[k]) begin
      run_op(pwc_pkg::PWC_OP_LOCK_CFG, lock_codes[k], 0, -1);
    end
    run_op(pwc_pkg::PWC_OP_LOCK_CFG, 8'h77, 0, -1);
    // refused code leaves the device in setup, so the next write is a bad second code
    sh.st = 8'hb0;
    run_op(pwc_pkg::PWC_OP_READ_STATUS, 8'h70, 0, -1);
    run_op(pwc_pkg::PWC_OP_BUF_PROG, 8'he8, 8, 3);
    run_op(pwc_pkg::PWC_OP_SUSPEND, 8'hb0, 0, -1);
    @(posedge i_clk);
    req       <= '{op: pwc_pkg::PWC_OP_CLEAR, bit_alt: 1'b0, code: 8'h50, addr: '0, count: '0};
    req_valid <= 1'b1;
    repeat (40) @(posedge i_clk);
    check("req_ready", 16'h0001, {15'h0000, o_req_ready});
    req_valid <= 1'b0;
    run_op(pwc_pkg::PWC_OP_RESUME, 8'hd0, 0, -1);
    run_op(pwc_pkg::PWC_OP_READ_STATUS, 8'h70, 0, -1);
    // host mirror says erase suspended, so the unlock code goes out as a second cycle
    run_op(pwc_pkg::PWC_OP_LOCK_CFG, 8'hd0, 0, -1);
    run_op(pwc_pkg::PWC_OP_CLEAR, 8'h50, 0, -1);
    summarize();
  end

  // watchdog well beyond the longest expected run
  initial begin
    repeat (50000) @(posedge i_clk);
    error_cnt++;
    summarize();
  end
endmodule : pwc_host_tb_top
